/* rtl/bkpt_pkg.sv */
// Shared constants for the breakpoint and debug controller and its core end
package bkpt_pkg;
   // ****************************************
   // Register offsets, device side
   // ****************************************
   localparam logic [15:0] ADDR_EXEC_LOW  = 16'ha098;
   localparam logic [15:0] ADDR_EXEC_HIGH = 16'ha099;
   localparam logic [15:0] ADDR_EXEC_TOP  = 16'ha09a;
   localparam logic [15:0] ADDR_NEXT_LOW  = 16'ha09b;
   localparam logic [15:0] ADDR_NEXT_HIGH = 16'ha09c;
   localparam logic [15:0] ADDR_NEXT_TOP  = 16'ha09d;
   localparam logic [15:0] ADDR_STEP_KEY  = 16'ha09e;
   localparam logic [15:0] ADDR_DBG_ID    = 16'ha09f;
   localparam logic [15:0] ADDR_BRK_FLAG  = 16'ha0e0;
   localparam logic [15:0] ADDR_BRK_IE    = 16'ha0e1;
   localparam logic [15:0] ADDR_SVC_CTRL  = 16'ha0e3;
   localparam logic [15:0] ADDR_B1_LOW    = 16'ha0f0;
   localparam logic [15:0] ADDR_B1_HIGH   = 16'ha0f1;
   localparam logic [15:0] ADDR_B1_TOP    = 16'ha0f2;
   localparam logic [15:0] ADDR_B2_LOW    = 16'ha0f4;
   localparam logic [15:0] ADDR_B2_HIGH   = 16'ha0f5;
   localparam logic [15:0] ADDR_B2_TOP    = 16'ha0f6;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int          SVC_IRQ_BIT    = 7;
   localparam int          SVC_WDT_BIT    = 6;
   localparam int          SVC_T2_BIT     = 5;
   localparam int          SVC_T1_BIT     = 4;
   localparam int          SVC_T0_BIT     = 3;
   localparam int          SVC_FLAG_BIT   = 0;
   localparam logic [7:0]  SVC_CTRL_RST   = 8'hfc;
   localparam logic [7:0]  SVC_WR_MASK    = 8'hf9;
   localparam logic [7:0]  SVC_ENTRY_CLR  = 8'h07;
   localparam int          FLG_B1_BIT     = 0;
   localparam int          FLG_B2_BIT     = 1;
   localparam int          FLG_STEP_BIT   = 7;
   localparam logic [7:0]  FLG_MASK       = 8'h83;
   localparam logic [7:0]  DBG_ID_RST     = 8'h36;
   localparam int          DBG_SEL_BIT    = 7;
   localparam logic [7:0]  STEP_KEY_VAL   = 8'h96;
   localparam logic [15:0] VEC_DEBUG      = 16'h70c0;
   localparam logic [15:0] VEC_BREAK      = 16'h7080;

   // ****************************************
   // Core end Avalon register map (word offsets)
   // ****************************************
   localparam logic [2:0]  AV_CMD         = 3'h0;
   localparam logic [2:0]  AV_FETCH_PC    = 3'h1;
   localparam logic [2:0]  AV_EXEC_PC     = 3'h2;
   localparam logic [2:0]  AV_SFR         = 3'h3;
   localparam logic [2:0]  AV_I2C_ADDR    = 3'h4;
   localparam logic [2:0]  AV_STATUS      = 3'h5;
   localparam int          CMD_FETCH      = 0;
   localparam int          CMD_RETI       = 1;
   localparam int          CMD_ENTER      = 2;
   localparam int          CMD_I2C        = 3;
   localparam int          CMD_SFR_WR     = 4;
   localparam int          CMD_SFR_RD     = 5;
endpackage

/* rtl/bkpt_link_if.sv */
// Link between the debug controller and the core fetch and SFR path
`timescale 1ns/1ns
interface bkpt_link_if;
   logic [15:0] sfr_addr;
   logic [7:0]  sfr_wdata;
   logic        sfr_wr;
   logic        sfr_rd;
   logic [7:0]  sfr_rdata;
   logic        fetch_valid;
   logic [23:0] fetch_pc;
   logic [23:0] exec_pc;
   logic        reti_fetch;
   logic        svc_enter;
   logic        i2c_valid;
   logic [6:0]  i2c_addr;
   logic        dbg_irq;
   logic        bkp_irq;
   logic [15:0] irq_vector;
   logic        irq_allow;
   logic        wdt_count_en;
   logic        t2_count_en;
   logic        t1_count_en;
   logic        t0_count_en;
   logic        service_active;

   modport device_mp (
      input  sfr_addr, sfr_wdata, sfr_wr, sfr_rd, fetch_valid, fetch_pc,
             exec_pc, reti_fetch, svc_enter, i2c_valid, i2c_addr,
      output sfr_rdata, dbg_irq, bkp_irq, irq_vector, irq_allow,
             wdt_count_en, t2_count_en, t1_count_en, t0_count_en,
             service_active
   );
   modport core_mp (
      output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, fetch_valid, fetch_pc,
             exec_pc, reti_fetch, svc_enter, i2c_valid, i2c_addr,
      input  sfr_rdata, dbg_irq, bkp_irq, irq_vector, irq_allow,
             wdt_count_en, t2_count_en, t1_count_en, t0_count_en,
             service_active
   );
endinterface // bkpt_link_if

/* rtl/breakpoint_debug_controller.sv */
// Breakpoint and debug controller: PC compare, capture, service control
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
module breakpoint_debug_controller
   import bkpt_pkg::*;
(
   // Clock and reset
   input  wire logic          i_core_clk,
   input  wire logic          i_reset_n,
   // Core link
   bkpt_link_if.device_mp     link
);
   import bkpt_pkg::*;

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0]  svc_ctrl_r, svc_ctrl_nxt;
   logic [7:0]  step_key_r, step_key_nxt;
   logic [7:0]  dbg_id_r, dbg_id_nxt;
   logic [7:0]  brk_flag_r, brk_flag_nxt;
   logic [7:0]  brk_ie_r, brk_ie_nxt;
   logic [23:0] brk_one_r, brk_one_nxt;
   logic [23:0] brk_two_r, brk_two_nxt;
   logic [23:0] exec_cap_r, exec_cap_nxt;
   logic [23:0] next_cap_r, next_cap_nxt;
   logic        dbg_pend_r, dbg_pend_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic        bkp_irq_r, bkp_irq_nxt;
   logic [15:0] vector_r, vector_nxt;
   logic [4:0]  allow_r, allow_nxt;

   logic        hit_one;
   logic        hit_two;
   logic        hit_step;
   logic        brk_event;
   logic [7:0]  flag_set;
   logic        wr;

   always_comb begin
      wr        = link.sfr_wr;
      // Full 24-bit fetch address compare, decided at fetch time
      hit_one   = link.fetch_valid && (link.fetch_pc == brk_one_r);
      hit_two   = link.fetch_valid && (link.fetch_pc == brk_two_r);
      hit_step  = link.fetch_valid && link.reti_fetch
                  && (step_key_r == STEP_KEY_VAL);
      flag_set  = 8'h00;
      flag_set[FLG_B1_BIT]   = hit_one;
      flag_set[FLG_B2_BIT]   = hit_two;
      flag_set[FLG_STEP_BIT] = hit_step;
      brk_event = |(flag_set & brk_ie_r);
   end

   // ****************************************
   // Register writes and hardware updates
   // ****************************************
   always_comb begin
      svc_ctrl_nxt = svc_ctrl_r;
      step_key_nxt = step_key_r;
      dbg_id_nxt   = dbg_id_r;
      brk_flag_nxt = brk_flag_r;
      brk_ie_nxt   = brk_ie_r;
      brk_one_nxt  = brk_one_r;
      brk_two_nxt  = brk_two_r;
      exec_cap_nxt = exec_cap_r;
      next_cap_nxt = next_cap_r;
      if (wr) begin
         if (link.sfr_addr == ADDR_SVC_CTRL) begin
            svc_ctrl_nxt = link.sfr_wdata & SVC_WR_MASK;
         end else if (link.sfr_addr == ADDR_STEP_KEY) begin
            step_key_nxt = link.sfr_wdata;
         end else if (link.sfr_addr == ADDR_DBG_ID) begin
            dbg_id_nxt = link.sfr_wdata;
         end else if (link.sfr_addr == ADDR_BRK_FLAG) begin
            brk_flag_nxt = link.sfr_wdata & FLG_MASK;
         end else if (link.sfr_addr == ADDR_BRK_IE) begin
            brk_ie_nxt = link.sfr_wdata & FLG_MASK;
         end else if (link.sfr_addr == ADDR_B1_LOW) begin
            brk_one_nxt[7:0] = link.sfr_wdata;
         end else if (link.sfr_addr == ADDR_B1_HIGH) begin
            brk_one_nxt[15:8] = link.sfr_wdata;
         end else if (link.sfr_addr == ADDR_B1_TOP) begin
            brk_one_nxt[23:16] = link.sfr_wdata;
         end else if (link.sfr_addr == ADDR_B2_LOW) begin
            brk_two_nxt[7:0] = link.sfr_wdata;
         end else if (link.sfr_addr == ADDR_B2_HIGH) begin
            brk_two_nxt[15:8] = link.sfr_wdata;
         end else if (link.sfr_addr == ADDR_B2_TOP) begin
            brk_two_nxt[23:16] = link.sfr_wdata;
         end
      end
      // Hardware set wins over a software clear in the same cycle
      brk_flag_nxt = brk_flag_nxt | flag_set;
      if (brk_event) begin
         exec_cap_nxt = link.exec_pc;
         next_cap_nxt = link.fetch_pc;
      end
      if (link.svc_enter) begin
         svc_ctrl_nxt = svc_ctrl_nxt & SVC_ENTRY_CLR & SVC_WR_MASK;
         svc_ctrl_nxt[SVC_FLAG_BIT] = 1'b1;
      end
   end

   // ****************************************
   // Interrupt requests, vector and allows
   // ****************************************
   always_comb begin
      dbg_pend_nxt = dbg_pend_r;
      if (link.svc_enter) begin
         dbg_pend_nxt = 1'b0;
      end
      if (link.i2c_valid && dbg_id_r[DBG_SEL_BIT]
          && (link.i2c_addr == dbg_id_r[6:0])) begin
         dbg_pend_nxt = 1'b1;
      end
      // Request follows the enable written this cycle, no stale level
      bkp_irq_nxt = |(brk_flag_nxt & brk_ie_nxt);
      // Debug request outranks breakpoints
      if (dbg_pend_nxt) begin
         vector_nxt = VEC_DEBUG;
      end else begin
         vector_nxt = VEC_BREAK;
      end
      // Outside service every allow is on; inside, the bit decides
      allow_nxt = svc_ctrl_nxt[7:3] | {5{~svc_ctrl_nxt[SVC_FLAG_BIT]}};
   end

   // ****************************************
   // Register read port
   // ****************************************
   always_comb begin
      rdata_nxt = rdata_r;
      if (link.sfr_rd) begin
         if (link.sfr_addr == ADDR_EXEC_LOW) begin
            rdata_nxt = exec_cap_r[7:0];
         end else if (link.sfr_addr == ADDR_EXEC_HIGH) begin
            rdata_nxt = exec_cap_r[15:8];
         end else if (link.sfr_addr == ADDR_EXEC_TOP) begin
            rdata_nxt = exec_cap_r[23:16];
         end else if (link.sfr_addr == ADDR_NEXT_LOW) begin
            rdata_nxt = next_cap_r[7:0];
         end else if (link.sfr_addr == ADDR_NEXT_HIGH) begin
            rdata_nxt = next_cap_r[15:8];
         end else if (link.sfr_addr == ADDR_NEXT_TOP) begin
            rdata_nxt = next_cap_r[23:16];
         end else if (link.sfr_addr == ADDR_STEP_KEY) begin
            rdata_nxt = step_key_r;
         end else if (link.sfr_addr == ADDR_DBG_ID) begin
            rdata_nxt = dbg_id_r;
         end else if (link.sfr_addr == ADDR_BRK_FLAG) begin
            rdata_nxt = brk_flag_r;
         end else if (link.sfr_addr == ADDR_BRK_IE) begin
            rdata_nxt = brk_ie_r;
         end else if (link.sfr_addr == ADDR_SVC_CTRL) begin
            rdata_nxt = svc_ctrl_r;
         end else if (link.sfr_addr == ADDR_B1_LOW) begin
            rdata_nxt = brk_one_r[7:0];
         end else if (link.sfr_addr == ADDR_B1_HIGH) begin
            rdata_nxt = brk_one_r[15:8];
         end else if (link.sfr_addr == ADDR_B1_TOP) begin
            rdata_nxt = brk_one_r[23:16];
         end else if (link.sfr_addr == ADDR_B2_LOW) begin
            rdata_nxt = brk_two_r[7:0];
         end else if (link.sfr_addr == ADDR_B2_HIGH) begin
            rdata_nxt = brk_two_r[15:8];
         end else if (link.sfr_addr == ADDR_B2_TOP) begin
            rdata_nxt = brk_two_r[23:16];
         end else begin
            rdata_nxt = 8'h00;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         svc_ctrl_r <= SVC_CTRL_RST;
         step_key_r <= 8'h00;
         dbg_id_r   <= DBG_ID_RST;
         brk_flag_r <= 8'h00;
         brk_ie_r   <= 8'h00;
         brk_one_r  <= 24'h000000;
         brk_two_r  <= 24'h000000;
         exec_cap_r <= 24'h000000;
         next_cap_r <= 24'h000000;
         dbg_pend_r <= 1'b0;
         rdata_r    <= 8'h00;
         bkp_irq_r  <= 1'b0;
         vector_r   <= VEC_BREAK;
         allow_r    <= 5'h1f;
      end else begin
         svc_ctrl_r <= svc_ctrl_nxt;
         step_key_r <= step_key_nxt;
         dbg_id_r   <= dbg_id_nxt;
         brk_flag_r <= brk_flag_nxt;
         brk_ie_r   <= brk_ie_nxt;
         brk_one_r  <= brk_one_nxt;
         brk_two_r  <= brk_two_nxt;
         exec_cap_r <= exec_cap_nxt;
         next_cap_r <= next_cap_nxt;
         dbg_pend_r <= dbg_pend_nxt;
         rdata_r    <= rdata_nxt;
         bkp_irq_r  <= bkp_irq_nxt;
         vector_r   <= vector_nxt;
         allow_r    <= allow_nxt;
      end
   end

   assign link.sfr_rdata      = rdata_r;
   assign link.dbg_irq        = dbg_pend_r;
   assign link.bkp_irq        = bkp_irq_r;
   assign link.irq_vector     = vector_r;
   assign link.irq_allow      = allow_r[4];
   assign link.wdt_count_en   = allow_r[3];
   assign link.t2_count_en    = allow_r[2];
   assign link.t1_count_en    = allow_r[1];
   assign link.t0_count_en    = allow_r[0];
   assign link.service_active = svc_ctrl_r[SVC_FLAG_BIT];

endmodule // breakpoint_debug_controller

/* rtl/core_debug_end.sv */
// Core end of the debug link, driven by software over Avalon-MM
`timescale 1ns/1ns
module core_debug_end
   import bkpt_pkg::*;
(
   // Clock and reset
   input  wire logic          i_core_clk,
   input  wire logic          i_reset_n,
   // Avalon-MM slave
   input  wire logic [2:0]    i_avs_address,
   input  wire logic          i_avs_read,
   input  wire logic          i_avs_write,
   input  wire logic [31:0]   i_avs_writedata,
   output logic      [31:0]   o_avs_readdata,
   output logic               o_avs_waitrequest,
   // Device link
   bkpt_link_if.core_mp       link
);
   import bkpt_pkg::*;

   // ****************************************
   // Registers
   // ****************************************
   logic        wait_r, wait_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [23:0] fetch_pc_r, fetch_pc_nxt;
   logic [23:0] exec_pc_r, exec_pc_nxt;
   logic [23:0] sfr_r, sfr_nxt;
   logic [6:0]  i2c_addr_r, i2c_addr_nxt;
   logic [5:0]  pulse_r, pulse_nxt;
   logic        rd_pend_r, rd_pend_nxt;
   logic [7:0]  sfr_data_r, sfr_data_nxt;
   logic        commit;

   always_comb begin
      commit       = (i_avs_write || i_avs_read) && !wait_r;
      wait_nxt     = !commit && (i_avs_write || i_avs_read) ? 1'b0 : 1'b1;
      rdata_nxt    = rdata_r;
      fetch_pc_nxt = fetch_pc_r;
      exec_pc_nxt  = exec_pc_r;
      sfr_nxt      = sfr_r;
      i2c_addr_nxt = i2c_addr_r;
      pulse_nxt    = 6'h00;
      rd_pend_nxt  = rd_pend_r;
      sfr_data_nxt = sfr_data_r;
      if (rd_pend_r) begin
         sfr_data_nxt = link.sfr_rdata;
         rd_pend_nxt  = 1'b0;
      end
      if (pulse_r[CMD_SFR_RD]) begin
         rd_pend_nxt = 1'b1;
      end
      if (i_avs_read && wait_r) begin
         if (i_avs_address == AV_FETCH_PC) begin
            rdata_nxt = {8'h00, fetch_pc_r};
         end else if (i_avs_address == AV_EXEC_PC) begin
            rdata_nxt = {8'h00, exec_pc_r};
         end else if (i_avs_address == AV_SFR) begin
            rdata_nxt = {sfr_data_r, sfr_r};
         end else if (i_avs_address == AV_I2C_ADDR) begin
            rdata_nxt = {25'h0000000, i2c_addr_r};
         end else if (i_avs_address == AV_STATUS) begin
            rdata_nxt = {link.irq_vector, 7'h00, rd_pend_r,
                         link.service_active, link.t0_count_en,
                         link.t1_count_en, link.t2_count_en,
                         link.wdt_count_en, link.irq_allow,
                         link.bkp_irq, link.dbg_irq};
         end else begin
            rdata_nxt = 32'h00000000;
         end
      end
      if (commit && i_avs_write) begin
         if (i_avs_address == AV_CMD) begin
            pulse_nxt = i_avs_writedata[5:0];
         end else if (i_avs_address == AV_FETCH_PC) begin
            fetch_pc_nxt = i_avs_writedata[23:0];
         end else if (i_avs_address == AV_EXEC_PC) begin
            exec_pc_nxt = i_avs_writedata[23:0];
         end else if (i_avs_address == AV_SFR) begin
            sfr_nxt = i_avs_writedata[23:0];
         end else if (i_avs_address == AV_I2C_ADDR) begin
            i2c_addr_nxt = i_avs_writedata[6:0];
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wait_r     <= 1'b1;
         rdata_r    <= 32'h00000000;
         fetch_pc_r <= 24'h000000;
         exec_pc_r  <= 24'h000000;
         sfr_r      <= 24'h000000;
         i2c_addr_r <= 7'h00;
         pulse_r    <= 6'h00;
         rd_pend_r  <= 1'b0;
         sfr_data_r <= 8'h00;
      end else begin
         wait_r     <= wait_nxt;
         rdata_r    <= rdata_nxt;
         fetch_pc_r <= fetch_pc_nxt;
         exec_pc_r  <= exec_pc_nxt;
         sfr_r      <= sfr_nxt;
         i2c_addr_r <= i2c_addr_nxt;
         pulse_r    <= pulse_nxt;
         rd_pend_r  <= rd_pend_nxt;
         sfr_data_r <= sfr_data_nxt;
      end
   end

   assign o_avs_readdata    = rdata_r;
   assign o_avs_waitrequest = wait_r;
   assign link.fetch_valid  = pulse_r[CMD_FETCH];
   assign link.reti_fetch   = pulse_r[CMD_RETI];
   assign link.svc_enter    = pulse_r[CMD_ENTER];
   assign link.i2c_valid    = pulse_r[CMD_I2C];
   assign link.sfr_wr       = pulse_r[CMD_SFR_WR];
   assign link.sfr_rd       = pulse_r[CMD_SFR_RD];
   assign link.fetch_pc     = fetch_pc_r;
   assign link.exec_pc      = exec_pc_r;
   assign link.sfr_addr     = sfr_r[15:0];
   assign link.sfr_wdata    = sfr_r[23:16];
   assign link.i2c_addr     = i2c_addr_r;

endmodule // core_debug_end

/* tb/breakpoint_debug_controller_sva.sv */
// Assertions on the link between the debug controller and the core end
`timescale 1ns/1ns
module breakpoint_debug_controller_sva
   import bkpt_pkg::*;
(
   // Clock and reset
   input wire logic        i_core_clk,
   input wire logic        i_reset_n,
   // Core to device
   input wire logic [15:0] sfr_addr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic        sfr_wr,
   input wire logic        sfr_rd,
   input wire logic        fetch_valid,
   input wire logic        reti_fetch,
   input wire logic        svc_enter,
   input wire logic        i2c_valid,
   input wire logic [6:0]  i2c_addr,
   // Device to core
   input wire logic [7:0]  sfr_rdata,
   input wire logic        dbg_irq,
   input wire logic        bkp_irq,
   input wire logic [15:0] irq_vector,
   input wire logic        irq_allow,
   input wire logic        wdt_count_en,
   input wire logic        t2_count_en,
   input wire logic        t1_count_en,
   input wire logic        t0_count_en,
   input wire logic        service_active
);
   logic [7:0] dbg_id_r;
   logic [7:0] dbg_id_nxt;
   logic [4:0] allows;
   assign allows = {irq_allow, wdt_count_en, t2_count_en, t1_count_en,
                    t0_count_en};
   // Shadow of the debug identifier register
   always_comb begin
      dbg_id_nxt = dbg_id_r;
      if (sfr_wr && sfr_addr == ADDR_DBG_ID) begin
         dbg_id_nxt = sfr_wdata;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dbg_id_r <= DBG_ID_RST;
      end else begin
         dbg_id_r <= dbg_id_nxt;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   property p_vector;
      irq_vector == (dbg_irq ? VEC_DEBUG : VEC_BREAK);
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector does not follow debug request");
   property p_idle_allow;
      !service_active |-> allows == 5'h1f;
   endproperty
   a_idle_allow: assert property (p_idle_allow)
      else $error("allows low outside service");
   property p_entry;
      svc_enter |=> service_active && allows == 5'h00;
   endproperty
   a_entry: assert property (p_entry)
      else $error("service entry did not suspend");
   property p_entry_dbg;
      svc_enter |=> !dbg_irq;
   endproperty
   a_entry_dbg: assert property (p_entry_dbg)
      else $error("debug request kept after entry");
   property p_dbg_hit;
      i2c_valid && dbg_id_r[7] && i2c_addr == dbg_id_r[6:0]
         |=> dbg_irq && irq_vector == VEC_DEBUG;
   endproperty
   a_dbg_hit: assert property (p_dbg_hit)
      else $error("identifier hit gave no debug request");
   property p_dbg_cause;
      $rose(dbg_irq) |-> $past(i2c_valid) && $past(dbg_id_r[7]);
   endproperty
   a_dbg_cause: assert property (p_dbg_cause)
      else $error("debug request without port access");
   property p_bkp_cause;
      $rose(bkp_irq) |-> $past(fetch_valid) || $past(sfr_wr);
   endproperty
   a_bkp_cause: assert property (p_bkp_cause)
      else $error("break request without cause");
   property p_ctrl_read;
      sfr_rd && sfr_addr == ADDR_SVC_CTRL && service_active
         |=> sfr_rdata == {allows, 3'b001};
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control read disagrees with allows");
   property p_ctrl_write;
      sfr_wr && sfr_addr == ADDR_SVC_CTRL && !svc_enter
         |=> service_active == sfr_wdata[0] &&
             (!service_active || allows == sfr_wdata[7:3]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control write not applied");
   property p_reti_hold;
      reti_fetch && !sfr_wr && !svc_enter
         |=> service_active == $past(service_active) &&
             allows == $past(allows);
   endproperty
   a_reti_hold: assert property (p_reti_hold)
      else $error("return changed service state");
endmodule // breakpoint_debug_controller_sva

/* tb/test_breakpoint_debug_controller.sv */
// Self-checking bench for the debug controller and its core end
`timescale 1ns/1ns
module test_breakpoint_debug_controller;
   import bkpt_pkg::*;
   logic        i_core_clk    = 1'b0;
   logic        i_reset_n     = 1'b0;
   logic [2:0]  avs_address   = 3'h0;
   logic        avs_read      = 1'b0;
   logic        avs_write     = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [31:0] rd;
   int          num_errors    = 0;
   int          checked       = 0;
   bkpt_link_if link_bus ();
   always #20 i_core_clk = ~i_core_clk;
   breakpoint_debug_controller i_breakpoint_debug_controller (
      .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(link_bus));
   core_debug_end i_core_debug_end (
      .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .i_avs_address(avs_address), .i_avs_read(avs_read),
      .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
      .link(link_bus));
   breakpoint_debug_controller_sva i_breakpoint_debug_controller_sva (
      .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .sfr_addr(link_bus.sfr_addr), .sfr_wdata(link_bus.sfr_wdata),
      .sfr_wr(link_bus.sfr_wr), .sfr_rd(link_bus.sfr_rd),
      .fetch_valid(link_bus.fetch_valid), .reti_fetch(link_bus.reti_fetch),
      .svc_enter(link_bus.svc_enter), .i2c_valid(link_bus.i2c_valid),
      .i2c_addr(link_bus.i2c_addr), .sfr_rdata(link_bus.sfr_rdata),
      .dbg_irq(link_bus.dbg_irq), .bkp_irq(link_bus.bkp_irq),
      .irq_vector(link_bus.irq_vector), .irq_allow(link_bus.irq_allow),
      .wdt_count_en(link_bus.wdt_count_en),
      .t2_count_en(link_bus.t2_count_en), .t1_count_en(link_bus.t1_count_en),
      .t0_count_en(link_bus.t0_count_en),
      .service_active(link_bus.service_active));
   // ****************************************
   // Bus cycles and comparison
   // ****************************************
   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic av(input logic wr, input logic [2:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_core_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      @(posedge i_core_clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge i_core_clk);
         n++;
      end
      if (n >= 50) begin
         num_errors++;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic sfr_wr(input logic [15:0] a, input logic [7:0] d);
      av(1'b1, AV_SFR, {8'h00, d, a});
      av(1'b1, AV_CMD, 32'h1 << CMD_SFR_WR);
   endtask
   task automatic sfr_rd(input logic [15:0] a);
      av(1'b1, AV_SFR, {16'h0000, a});
      av(1'b1, AV_CMD, 32'h1 << CMD_SFR_RD);
      repeat (3) @(posedge i_core_clk);
      av(1'b0, AV_SFR, 32'h0);
      rd = {24'h0, rd[31:24]};
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_values();
      for (int i = 0; i < 6; i++) begin
         sfr_rd(ADDR_EXEC_LOW + 16'(i));
         check(32'h0, rd);
         sfr_wr(ADDR_EXEC_LOW + 16'(i), 8'hff);
         sfr_rd(ADDR_EXEC_LOW + 16'(i));
         check(32'h0, rd);
      end
      sfr_rd(ADDR_SVC_CTRL);
      check(32'hfc, rd);
      sfr_rd(ADDR_STEP_KEY);
      check(32'h0, rd);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h7080007c, rd);
   endtask
   task automatic t_break(input logic [15:0] base, input logic [7:0] ie,
                          input logic [23:0] pc);
      logic [23:0] ex;
      ex = pc - 24'h3;
      for (int i = 0; i < 3; i++) begin
         sfr_wr(base + 16'(i), pc[8*i+:8]);
      end
      sfr_wr(ADDR_BRK_IE, ie);
      av(1'b1, AV_EXEC_PC, {8'h0, ex});
      av(1'b1, AV_FETCH_PC, {8'h0, pc ^ 24'h800000});
      av(1'b1, AV_CMD, 32'h1 << CMD_FETCH);
      sfr_rd(ADDR_BRK_FLAG);
      check(32'h0, rd);
      av(1'b1, AV_FETCH_PC, {8'h0, pc});
      av(1'b1, AV_CMD, 32'h1 << CMD_FETCH);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h7080007e, rd);
      sfr_rd(ADDR_BRK_FLAG);
      check({24'h0, ie}, rd);
      for (int i = 0; i < 3; i++) begin
         sfr_rd(ADDR_EXEC_LOW + 16'(i));
         check({24'h0, ex[8*i+:8]}, rd);
         sfr_rd(ADDR_NEXT_LOW + 16'(i));
         check({24'h0, pc[8*i+:8]}, rd);
      end
      sfr_wr(ADDR_BRK_FLAG, 8'h00);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h7080007c, rd);
   endtask
   task automatic t_service();
      av(1'b1, AV_CMD, 32'h1 << CMD_ENTER);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h70800080, rd);
      sfr_rd(ADDR_SVC_CTRL);
      check(32'h01, rd);
      sfr_wr(ADDR_SVC_CTRL, 8'h49);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h708000c8, rd);
      av(1'b1, AV_FETCH_PC, 32'h100);
      av(1'b1, AV_CMD, 32'h3);
      sfr_rd(ADDR_SVC_CTRL);
      check(32'h49, rd);
      sfr_wr(ADDR_SVC_CTRL, 8'hf8);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h7080007c, rd);
   endtask
   task automatic t_step();
      sfr_wr(ADDR_BRK_IE, 8'h80);
      sfr_wr(ADDR_STEP_KEY, 8'h95);
      av(1'b1, AV_CMD, 32'h3);
      sfr_rd(ADDR_BRK_FLAG);
      check(32'h0, rd);
      sfr_wr(ADDR_STEP_KEY, STEP_KEY_VAL);
      av(1'b1, AV_CMD, 32'h1 << CMD_FETCH);
      sfr_rd(ADDR_BRK_FLAG);
      check(32'h0, rd);
      av(1'b1, AV_CMD, 32'h3);
      sfr_rd(ADDR_BRK_FLAG);
      check(32'h80, rd);
   endtask
   task automatic t_debug_port();
      av(1'b1, AV_I2C_ADDR, 32'h36);
      av(1'b1, AV_CMD, 32'h1 << CMD_I2C);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h7080007e, rd);
      sfr_wr(ADDR_DBG_ID, 8'hab);
      av(1'b1, AV_I2C_ADDR, 32'h2a);
      av(1'b1, AV_CMD, 32'h1 << CMD_I2C);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h7080007e, rd);
      av(1'b1, AV_I2C_ADDR, 32'h2b);
      av(1'b1, AV_CMD, 32'h1 << CMD_I2C);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h70c0007f, rd);
      av(1'b1, AV_CMD, 32'h1 << CMD_ENTER);
      av(1'b0, AV_STATUS, 32'h0);
      check(32'h70800082, rd);
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      t_reset_values();
      t_break(ADDR_B1_LOW, 8'h01, 24'h123456);
      t_break(ADDR_B2_LOW, 8'h02, 24'hfedcba);
      t_service();
      t_step();
      t_debug_port();
      final_report();
   end
   initial begin
      #1000000;
      num_errors++;
      final_report();
   end
endmodule // test_breakpoint_debug_controller
